// ---- rtl/cofs_regs.sv ----
/*
 * Comparator override register and state machine status register.
 * Assumes a synchronous single-cycle register port from the control
 * interface, comparator outputs from analogue (synchronised here) and
 * state machine codes from logic on the same clock.
 * A two-stage synchroniser module sits at the end of the file.
 */
`timescale 1ns/1ps
module cofs_regs
	import cofs_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        reset_in,
	// Register port
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [15:0] reg_wdata_in,
	output logic      [15:0] reg_rdata_out,
	// Override enable and comparators
	input  wire logic        comparator_force_enable_in,
	input  wire cofs_cmp_t   cmp_raw_in,
	output cofs_cmp_t        cmp_debounce_out,
	// State machine codes
	input  wire logic [2:0]  supply_path_state_in,
	input  wire logic [2:0]  charger_state_in,
	input  wire logic [3:0]  main_power_state_in
);

	// ------------------------------------------------------------
	// Comparator synchroniser
	// ------------------------------------------------------------
	cofs_cmp_t   cmp_sync_ff;

	// Raw comparators are asynchronous to this clock
	cofs_sync2
	#(
		.WIDTH ($bits(cofs_cmp_t))
	)
	u_cmp_sync
	(
		.sys_clk_in (sys_clk_in),
		.reset_in   (reset_in),
		.async_in   (cmp_raw_in),
		.sync_out   (cmp_sync_ff)
	);

	// ------------------------------------------------------------
	// Written override values
	// ------------------------------------------------------------
	cofs_cmp_t   force_ff;
	cofs_cmp_t   nxt_force;
	logic        ovr_wr;
	logic [15:0] wr_ovr;

	assign ovr_wr = reg_wr_in && (reg_addr_in == CMP_OVR_ADDR);
	assign wr_ovr = reg_wdata_in & CMP_OVR_MASK;

	// Bits 12 and 7:0 of the write word are dropped
	always_comb
	begin
		nxt_force = force_ff;
		if (ovr_wr)
		begin
			nxt_force.bus_supply     = wr_ovr[BUS_SUP_BIT];
			nxt_force.adaptor_supply = wr_ovr[ADAPT_SUP_BIT];
			nxt_force.battery        = wr_ovr[BATT_BIT];
			nxt_force.jack_left      = wr_ovr[JACK_L_BIT];
			nxt_force.jack_right     = wr_ovr[JACK_R_BIT];
			nxt_force.mic_short      = wr_ovr[MIC_SHORT_BIT];
			nxt_force.mic_detect     = wr_ovr[MIC_DET_BIT];
		end
	end

	// Held written values survive until the next write
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
			force_ff <= cofs_cmp_t'({CMP_OVR_RESET[15:13],
				CMP_OVR_RESET[11:8]});
		else
			force_ff <= nxt_force;
	end

	// ------------------------------------------------------------
	// Debounce feed
	// ------------------------------------------------------------
	cofs_cmp_t   nxt_debounce;

	// Written values replace the comparators while forcing
	always_comb
	begin
		if (comparator_force_enable_in)
			nxt_debounce = force_ff;
		else
			nxt_debounce = cmp_sync_ff;
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
			cmp_debounce_out <= '0;
		else
			cmp_debounce_out <= nxt_debounce;
	end

	// ------------------------------------------------------------
	// Status capture
	// ------------------------------------------------------------
	logic [2:0]  supply_ff;
	logic [2:0]  charger_ff;
	logic [3:0]  main_ff;

	// Register writes never reach this capture
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			supply_ff  <= SUPPLY_RESET;
			charger_ff <= CHARGER_RESET;
			main_ff    <= MAIN_RESET;
		end
		else
		begin
			supply_ff  <= supply_path_state_in;
			charger_ff <= charger_state_in;
			main_ff    <= main_power_state_in;
		end
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	logic [15:0] ovr_word;
	logic [15:0] stat_word;
	logic [15:0] nxt_rdata;

	// Raw comparator levels, not the written force values
	always_comb
	begin
		ovr_word = 16'h0000;
		ovr_word[BUS_SUP_BIT]   = cmp_sync_ff.bus_supply;
		ovr_word[ADAPT_SUP_BIT] = cmp_sync_ff.adaptor_supply;
		ovr_word[BATT_BIT]      = cmp_sync_ff.battery;
		ovr_word[JACK_L_BIT]    = cmp_sync_ff.jack_left;
		ovr_word[JACK_R_BIT]    = cmp_sync_ff.jack_right;
		ovr_word[MIC_SHORT_BIT] = cmp_sync_ff.mic_short;
		ovr_word[MIC_DET_BIT]   = cmp_sync_ff.mic_detect;
	end

	always_comb
	begin
		stat_word = 16'h0000;
		stat_word[SUPPLY_LSB +: 3]  = supply_ff;
		stat_word[CHARGER_LSB +: 3] = charger_ff;
		stat_word[MAIN_LSB +: 4]    = main_ff;
	end

	// Unmapped addresses read as zero
	always_comb
	begin
		case (reg_addr_in)
			CMP_OVR_ADDR: nxt_rdata = ovr_word;
			SM_STAT_ADDR: nxt_rdata = stat_word;
			default:      nxt_rdata = 16'h0000;
		endcase
	end

	// Read data holds between read strobes
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
			reg_rdata_out <= 16'h0000;
		else if (reg_rd_in)
			reg_rdata_out <= nxt_rdata;
	end

endmodule : cofs_regs

// ------------------------------------------------------------
// Two-stage synchroniser for asynchronous inputs
// ------------------------------------------------------------
module cofs_sync2
#(
	parameter int WIDTH = 7
)
(
	// Clock and reset
	input  wire logic             sys_clk_in,
	input  wire logic             reset_in,
	// Asynchronous input and synchronised output
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	// Only the second stage is visible to logic
	logic [WIDTH-1:0] meta_ff;

	// Reset both stages so no stale level survives
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			meta_ff  <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_ff  <= async_in;
			sync_out <= meta_ff;
		end
	end

endmodule : cofs_sync2

// ---- rtl/cofs_pkg.sv ----
/*
 * Package for the comparator override and state machine status registers.
 * Assumes a 16-bit register port with 8-bit register addresses.
 */
package cofs_pkg;

	// ------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------
	localparam logic [7:0]  CMP_OVR_ADDR   = 8'he7;
	localparam logic [7:0]  SM_STAT_ADDR   = 8'he9;

	// ------------------------------------------------------------
	// Override register fields
	// ------------------------------------------------------------
	localparam int          BUS_SUP_BIT    = 15;
	localparam int          ADAPT_SUP_BIT  = 14;
	localparam int          BATT_BIT       = 13;
	localparam int          JACK_L_BIT     = 11;
	localparam int          JACK_R_BIT     = 10;
	localparam int          MIC_SHORT_BIT  = 9;
	localparam int          MIC_DET_BIT    = 8;
	localparam logic [15:0] CMP_OVR_MASK   = 16'hef00;
	localparam logic [15:0] CMP_OVR_RESET  = 16'h0000;

	// ------------------------------------------------------------
	// Status register fields
	// ------------------------------------------------------------
	localparam int          SUPPLY_LSB     = 8;
	localparam int          CHARGER_LSB    = 4;
	localparam int          MAIN_LSB       = 0;
	localparam logic [2:0]  SUPPLY_RESET   = 3'h0;
	localparam logic [2:0]  CHARGER_RESET  = 3'h0;
	localparam logic [3:0]  MAIN_RESET     = 4'h0;

	// ------------------------------------------------------------
	// State encodings
	// ------------------------------------------------------------
	localparam logic [2:0]  SUP_SLAVE_100  = 3'h1;
	localparam logic [2:0]  SUP_SLAVE_500  = 3'h5;
	localparam logic [2:0]  SUP_SUSPEND    = 3'h4;
	localparam logic [2:0]  SUP_MST_LINE   = 3'h2;
	localparam logic [2:0]  SUP_MST_DCDC   = 3'h6;
	localparam logic [2:0]  CHG_OFF        = 3'h0;
	localparam logic [2:0]  CHG_TRICKLE    = 3'h1;
	localparam logic [2:0]  CHG_TRK_CHOKE  = 3'h2;
	localparam logic [2:0]  CHG_TRK_OTEMP  = 3'h3;
	localparam logic [2:0]  CHG_FAST       = 3'h4;
	localparam logic [2:0]  CHG_FAST_CHOKE = 3'h6;
	localparam logic [2:0]  CHG_FAST_OTEMP = 3'h5;
	localparam logic [3:0]  MAIN_OFF       = 4'h2;
	localparam logic [3:0]  MAIN_PRE_ACT   = 4'hd;
	localparam logic [3:0]  MAIN_HIBERNATE = 4'hc;
	localparam logic [3:0]  MAIN_ACTIVE    = 4'hf;

	// ------------------------------------------------------------
	// Comparator group carried as one struct
	// ------------------------------------------------------------
	typedef struct packed {
		logic bus_supply;
		logic adaptor_supply;
		logic battery;
		logic jack_left;
		logic jack_right;
		logic mic_short;
		logic mic_detect;
	} cofs_cmp_t;

endpackage : cofs_pkg

// ---- tb/cofs_regs_props.sv ----
/* Checker for the override and status register ports.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module cofs_regs_props
	import cofs_pkg::*;
(
	// Watched ports
	input wire logic        sys_clk_in,
	input wire logic        reset_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [7:0]  reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic        comparator_force_enable_in,
	input wire cofs_cmp_t   cmp_raw_in,
	input wire cofs_cmp_t   cmp_debounce_out,
	input wire logic [2:0]  supply_path_state_in,
	input wire logic [2:0]  charger_state_in,
	input wire logic [3:0]  main_power_state_in
);
	// ----------------------------------------
	// Written force value
	// ----------------------------------------
	cofs_cmp_t frc_ff;
	always_ff @(posedge sys_clk_in)
		if (reset_in)
			frc_ff <= '0;
		else if (reg_wr_in && reg_addr_in == CMP_OVR_ADDR)
			frc_ff <= {reg_wdata_in[15:13], reg_wdata_in[11:8]};
	default clocking cb @(posedge sys_clk_in); endclocking
	a_rst_rdata: assert property (reset_in |=> reg_rdata_out == 16'h0000)
		else $error("read data not cleared");
	a_rst_dbnc: assert property (reset_in |=> cmp_debounce_out == '0)
		else $error("debounce feed not cleared");
	a_stat_read: assert property (disable iff (reset_in)
		reg_rd_in && reg_addr_in == SM_STAT_ADDR && !$past(reset_in)
		&& $stable(supply_path_state_in) && $stable(charger_state_in)
		&& $stable(main_power_state_in) |=> reg_rdata_out ==
		{5'h00, $past(supply_path_state_in), 1'b0, $past(charger_state_in),
		$past(main_power_state_in)}) else $error("status readback wrong");
	a_ovr_read: assert property ((!reset_in && $stable(cmp_raw_in))[*4]
		##0 (reg_rd_in && reg_addr_in == CMP_OVR_ADDR) |=> reg_rdata_out ==
		{$past(cmp_raw_in[6:4]), 1'b0, $past(cmp_raw_in[3:0]), 8'h00})
		else $error("override readback wrong");
	a_force_feed: assert property (disable iff (reset_in)
		comparator_force_enable_in |=> cmp_debounce_out == $past(frc_ff))
		else $error("forced feed wrong");
	a_raw_feed: assert property ((!reset_in && $stable(cmp_raw_in))[*4]
		##0 !comparator_force_enable_in |=> cmp_debounce_out == $past(cmp_raw_in))
		else $error("raw feed wrong");
	a_rdata_hold: assert property (disable iff (reset_in)
		!reg_rd_in |=> $stable(reg_rdata_out)) else $error("read data moved");
	a_unmapped_zero: assert property (disable iff (reset_in) reg_rd_in
		&& reg_addr_in != CMP_OVR_ADDR && reg_addr_in != SM_STAT_ADDR
		|=> reg_rdata_out == 16'h0000) else $error("unmapped read not zero");
endmodule : cofs_regs_props
bind cofs_regs cofs_regs_props u_props (.*);

// ---- tb/test_comparator_override_and_fsm_status.sv ----
/* Bench for the override and status registers, random and corner traffic.
   Assumes the checker is bound to the design. */
`timescale 1ns/1ps
module test_comparator_override_and_fsm_status
	import cofs_pkg::*;
;
	logic clk = 0, rst = 1, wr = 0, rd = 0, en = 0;
	logic [7:0] addr = '0;
	logic [15:0] wd = '0, rdat, d, w, ex;
	cofs_cmp_t raw = '1, dbnc;
	logic [2:0] sup = SUP_SUSPEND, chg = CHG_FAST;
	logic [3:0] mn = MAIN_ACTIVE;
	logic [2:0] sup_t[5] = '{SUP_SLAVE_100, SUP_SLAVE_500, SUP_SUSPEND,
		SUP_MST_LINE, SUP_MST_DCDC};
	logic [2:0] chg_t[7] = '{CHG_OFF, CHG_TRICKLE, CHG_TRK_CHOKE,
		CHG_TRK_OTEMP, CHG_FAST, CHG_FAST_CHOKE, CHG_FAST_OTEMP};
	logic [3:0] mn_t[4] = '{MAIN_OFF, MAIN_PRE_ACT, MAIN_HIBERNATE, MAIN_ACTIVE};
	int fail_count = 0, samples_checked = 0;
	always #25 clk = ~clk;
	cofs_regs u_dut (.sys_clk_in(clk), .reset_in(rst), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wd),
		.reg_rdata_out(rdat), .comparator_force_enable_in(en),
		.cmp_raw_in(raw), .cmp_debounce_out(dbnc),
		.supply_path_state_in(sup), .charger_state_in(chg),
		.main_power_state_in(mn));
	function automatic logic [15:0] ovr(cofs_cmp_t c);
		return {c[6:4], 1'b0, c[3:0], 8'h00};
	endfunction : ovr
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic acc(input logic w_n, input logic [7:0] a, input logic [15:0] v);
		{wr, rd, addr, wd} = {w_n, !w_n, a, v};
		@(negedge clk);
		{wr, rd} = 2'b00;
		d = rdat;
		@(negedge clk);
	endtask : acc
	task automatic finish_test();
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test
	initial
	begin
		#100000;
		fail_count++;
		finish_test();
	end
	initial
	begin
		void'($urandom(15));
		repeat (4) @(negedge clk);
		rst = 0;
		acc(0, SM_STAT_ADDR, 16'h0000);
		chk(d, 16'h0000);
		chk({9'h000, dbnc}, 16'h0000);
		en = 1;
		@(negedge clk);
		chk({9'h000, dbnc}, 16'h0000);
		en = 0;
		$display("reset test done");
		for (int i = 0; i < 7; i++)
		begin
			{sup, chg, mn} = {sup_t[i % 5], chg_t[i], mn_t[i % 4]};
			ex = {5'h00, sup, 1'b0, chg, mn};
			@(negedge clk);
			acc(0, SM_STAT_ADDR, 16'h0000);
			chk(d, ex);
			acc(1, SM_STAT_ADDR, 16'($urandom));
			acc(0, SM_STAT_ADDR, 16'h0000);
			chk(d, ex);
		end
		$display("status test done");
		for (int i = 0; i < 20; i++)
		begin
			raw = cofs_cmp_t'($urandom);
			repeat (4) @(negedge clk);
			acc(0, CMP_OVR_ADDR, 16'h0000);
			chk(d, ovr(raw));
			chk({9'h000, dbnc}, {9'h000, raw});
			w = (i == 0) ? 16'hffff : 16'($urandom);
			acc(1, CMP_OVR_ADDR, w);
			en = 1;
			@(negedge clk);
			chk({9'h000, dbnc}, {9'h000, w[15:13], w[11:8]});
			acc(0, CMP_OVR_ADDR, 16'h0000);
			chk(d, ovr(raw));
			en = 0;
			acc(0, (i == 0) ? 8'he8 : 8'($urandom % 231), 16'h0000);
			chk(d, 16'h0000);
		end
		$display("override test done");
		finish_test();
	end
endmodule : test_comparator_override_and_fsm_status
